/* File: rtv_pkg.sv */
// Package for the real-time clock time value registers: offsets, field layouts, states.
// Assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock.
// Function
// R01: When the window pointer is 01 the shared window shows the weekday-and-hours view.
// R02: When the window pointer is 00 the shared window shows the minutes-and-seconds view.
// R03: Bits 10..8 of the weekday-and-hours view hold the weekday digit, 0 to 6.
// R04: Bits 5..4 of the weekday-and-hours view hold the hour tens digit, 0 to 2.
// R05: Bits 3..0 of the weekday-and-hours view hold the hour ones digit, 0 to 9.
// R06: Bits 14..12 of the minutes-and-seconds view hold the minute tens digit, 0 to 5.
// R07: Bits 11..8 of the minutes-and-seconds view hold the minute ones digit, 0 to 9.
// R08: Bits 6..4 of the minutes-and-seconds view hold the second tens digit, 0 to 5.
// R09: Bits 3..0 of the minutes-and-seconds view hold the second ones digit, 0 to 9.
// R10: Writes to the weekday-and-hours view take effect only while write enable is 1.
// R11: Bits that carry no time field read zero and ignore writes.
// R12: Time fields have no defined value after reset until software loads them.
package rtv_pkg;
  localparam logic [3:0]  ctrl_offset   = 4'h0;
  localparam logic [3:0]  window_offset = 4'h4;
  localparam logic [1:0]  ptr_min_sec   = 2'h0;
  localparam logic [1:0]  ptr_weekday_digit_hr   = 2'h1;
  localparam int          ptr_lsb       = 0;
  localparam int          wren_bit      = 8;
  localparam logic [15:0] weekday_digit_hr_mask  = 16'h073f;
  localparam logic [15:0] min_sec_mask  = 16'h7f7f;
  localparam logic [1:0]  resp_okay     = 2'h0;
  localparam logic [1:0]  resp_slverr   = 2'h2;
  localparam logic [1:0]  ptr_reset     = 2'h0;
  localparam logic        wren_reset    = 1'b0;
  localparam int          view_count    = 2;

  typedef struct packed {
    logic [4:0] pad;
    logic [2:0] weekday_digit;
    logic [1:0] pad2;
    logic [1:0] hour_tens_digit;
    logic [3:0] hour_ones_digit;
  } rtv_weekday_digit_hr_t;

  typedef struct packed {
    logic       pad;
    logic [2:0] minute_tens_digit;
    logic [3:0] minute_ones_digit;
    logic       pad2;
    logic [2:0] second_tens_digit;
    logic [3:0] second_ones_digit;
  } rtv_min_sec_t;

  typedef enum logic [1:0] {
    rtv_idle = 2'b01,
    rtv_resp = 2'b10
  } rtv_state_t;
endpackage : rtv_pkg

/* File: rtv_view_reg.sv */
// One 16-bit time view register with a field mask.
// Assumes the parent qualifies the write strobe.
`timescale 1ns/1ns
module rtv_view_reg #(
  parameter logic [15:0] mask = 16'hffff
) (
  input  wire logic        core_clk,
  input  wire logic        clk_en,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  wstrb,
  output logic      [15:0] value
);
  logic [15:0] store;

  // No reset: contents are undefined until software loads the time [R12]
  always_ff @(posedge core_clk)
  begin
    if (clk_en && wr)
    begin
      if (wstrb[0])
        store[7:0] <= wdata[7:0];
      if (wstrb[1])
        store[15:8] <= wdata[15:8];
    end
  end

  assign value = store & mask; // [R11]
endmodule : rtv_view_reg

/* File: rtv_time_value.sv */
// Time value window of the calendar: pointer, write enable and two BCD views.
// Assumes an AXI4-Lite master with at most one read and one write in flight.
`timescale 1ns/1ns
module rtv_time_value (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import rtv_pkg::*;

  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [1:0]  value_window_pointer;
  logic        clock_write_enable;
  logic [15:0] view_value [view_count];
  logic [view_count-1:0] view_wr;
  logic        wr_fire;
  logic [15:0] shared_value_window;
  rtv_state_t  wr_state;
  rtv_state_t  rd_state;

  assign wr_fire = (wr_state == rtv_idle) && aw_held && w_held;

  // Address and data are taken independently, each once per write
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else if (clk_en)
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && wr_state == rtv_idle;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && wr_state == rtv_idle;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_state     <= rtv_idle;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end
    else if (clk_en)
    begin
      case (wr_state)
        rtv_idle:
        begin
          if (wr_fire)
          begin
            wr_state     <= rtv_resp;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == ctrl_offset || aw_addr == window_offset)
                            ? resp_okay : resp_slverr;
          end
        end
        rtv_resp:
        begin
          if (s_axi_bready)
          begin
            wr_state     <= rtv_idle;
            s_axi_bvalid <= 1'b0;
          end
        end
        default:
        begin
          wr_state     <= rtv_idle;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Control word: pointer in bits 1..0, write enable in bit 8
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      value_window_pointer <= ptr_reset;
      clock_write_enable   <= wren_reset;
    end
    else if (clk_en && wr_fire && aw_addr == ctrl_offset)
    begin
      if (w_strb[0])
        value_window_pointer <= w_data[ptr_lsb+1:ptr_lsb];
      if (w_strb[1])
        clock_write_enable <= w_data[wren_bit];
    end
  end

  // Pointer values 10 and 11 select no view, so writes there are dropped
  assign view_wr[0] = wr_fire && aw_addr == window_offset
                      && value_window_pointer == ptr_min_sec; // [R02]
  assign view_wr[1] = wr_fire && aw_addr == window_offset && clock_write_enable
                      && value_window_pointer == ptr_weekday_digit_hr; // [R01] [R10]

  genvar gi;
  generate
    for (gi = 0; gi < view_count; gi++)
    begin : g_view
      rtv_view_reg #(
        .mask (gi == 0 ? min_sec_mask : weekday_digit_hr_mask) // [R03] [R04] [R05] [R06] [R07] [R08] [R09] [R11]
      ) u_view (
        .core_clk (core_clk),
        .clk_en   (clk_en),
        .wr       (view_wr[gi]),
        .wdata    (w_data[15:0]),
        .wstrb    (w_strb[1:0]),
        .value    (view_value[gi])
      );
    end
  endgenerate

  always_comb
  begin
    case (value_window_pointer)
      ptr_min_sec: shared_value_window = view_value[0]; // [R02]
      ptr_weekday_digit_hr: shared_value_window = view_value[1]; // [R01]
      default:     shared_value_window = 16'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_state      <= rtv_idle;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= resp_okay;
    end
    else if (clk_en)
    begin
      case (rd_state)
        rtv_idle:
        begin
          s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
          if (s_axi_arvalid && s_axi_arready)
          begin
            rd_state     <= rtv_resp;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= resp_okay;
            if (s_axi_araddr == ctrl_offset)
              s_axi_rdata <= {23'h0, clock_write_enable, 6'h0, value_window_pointer};
            else if (s_axi_araddr == window_offset)
              s_axi_rdata <= {16'h0, shared_value_window}; // [R11]
            else
            begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= resp_slverr;
            end
          end
        end
        rtv_resp:
        begin
          s_axi_arready <= 1'b0;
          if (s_axi_rready)
          begin
            rd_state     <= rtv_idle;
            s_axi_rvalid <= 1'b0;
          end
        end
        default:
        begin
          rd_state     <= rtv_idle;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  a_weekday_digit_locked: assert property (@(posedge core_clk) disable iff (!reset_n)
    // Views hold unknowns until first loaded, so compare case-exactly
    clk_en && !clock_write_enable |=> view_value[1] === $past(view_value[1]) || $past(!clk_en))
    else $error("weekday view changed while locked"); // [R10]
  a_unused_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    (view_value[0] & ~min_sec_mask) == 16'h0 && (view_value[1] & ~weekday_digit_hr_mask) == 16'h0)
    else $error("unused view bit nonzero"); // [R11]
  a_window_minsec: assert property (@(posedge core_clk) disable iff (!reset_n)
    value_window_pointer == ptr_min_sec |-> shared_value_window === view_value[0])
    else $error("window not minutes view"); // [R02]
  a_window_wdayhr: assert property (@(posedge core_clk) disable iff (!reset_n)
    value_window_pointer == ptr_weekday_digit_hr |-> shared_value_window === view_value[1])
    else $error("window not weekday view"); // [R01]
  a_read_window: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_en && rd_state == rtv_idle && s_axi_arvalid && s_axi_arready
    && s_axi_araddr == window_offset
    |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0)
    else $error("window read upper bits nonzero"); // [R11]
  a_write_minsec: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_en && view_wr[0] && w_strb[1:0] == 2'h3
    |=> !clk_en || view_value[0] == ($past(w_data[15:0]) & min_sec_mask))
    else $error("minutes view write lost"); // [R06] [R07] [R08] [R09]
  a_write_wdayhr: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_en && view_wr[1] && w_strb[1:0] == 2'h3
    |=> !clk_en || view_value[1] == ($past(w_data[15:0]) & weekday_digit_hr_mask))
    else $error("weekday view write lost"); // [R03] [R04] [R05] [R10]
  a_bresp_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_en && wr_fire |=> s_axi_bvalid)
    else $error("write response missing");
endmodule : rtv_time_value

/* File: rtc_time_value_access_tb_top.sv */
// Self-checking bench for the time value window over AXI4-Lite.
// Assumes rtv_pkg and rtv_time_value are compiled first; one 250 MHz clock.
`timescale 1ns/1ns
module rtc_time_value_access_tb_top;
  import rtv_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  int          fails = 0;
  int          n_compared = 0;

  always #2 core_clk = ~core_clk;

  rtv_time_value uut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Address and data offered together; each valid drops once its own ready is seen
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50)
    begin
      fails++;
      tally_and_finish();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50)
    begin
      fails++;
      tally_and_finish();
    end
  endtask : axi_rd

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, resp_okay});
  endtask : wr

  task automatic rd_exp(input string nm, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check("rresp", {30'h0, r}, {30'h0, resp_okay});
    check(nm, d, exp);
  endtask : rd_exp

  // Time views carry no reset value, so only the control word is looked at here
  task automatic t_reset;
    rd_exp("ctrl reset", ctrl_offset, 32'h0);
  endtask : t_reset

  task automatic t_min_sec;
    wr(window_offset, 32'h0000_5959);
    rd_exp("min sec top", window_offset, 32'h5959);
    wr(window_offset, 32'h0000_3047);
    rd_exp("min sec fields", window_offset, 32'h3047);
    wr(window_offset, 32'hffff_ffff);
    rd_exp("min sec unused", window_offset, 32'h7f7f);
  endtask : t_min_sec

  task automatic t_weekday_digit_hr;
    wr(ctrl_offset, 32'h0000_0101);
    wr(window_offset, 32'h0000_0623);
    rd_exp("weekday_digit hr fields", window_offset, 32'h0623);
    wr(window_offset, 32'hffff_ffff);
    rd_exp("weekday_digit hr unused", window_offset, 32'h073f);
    wr(ctrl_offset, 32'h0000_0100);
    rd_exp("min sec kept", window_offset, 32'h7f7f);
  endtask : t_weekday_digit_hr

  task automatic t_wren_gate;
    wr(ctrl_offset, 32'h0000_0001);
    wr(window_offset, 32'h0000_0512);
    rd_exp("gated write", window_offset, 32'h073f);
    wr(ctrl_offset, 32'h0000_0101);
    wr(window_offset, 32'h0000_0512);
    rd_exp("enabled write", window_offset, 32'h0512);
  endtask : t_wren_gate

  // Unmapped offset must answer an error and leave the control word alone
  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(4'h8, 32'h0000_0002, r);
    check("unmapped bresp", {30'h0, r}, {30'h0, resp_slverr});
    axi_rd(4'h8, d, r);
    check("unmapped rresp", {30'h0, r}, {30'h0, resp_slverr});
    check("unmapped rdata", d, 32'h0);
    rd_exp("ctrl kept", ctrl_offset, 32'h0101);
  endtask : t_unmapped

  // Pointer codes 10 and 11 select no view: window reads zero, writes are dropped
  task automatic t_ptr_unused;
    wr(ctrl_offset, 32'hffff_ffff);
    rd_exp("ctrl unused", ctrl_offset, 32'h0103);
    rd_exp("ptr 11 window", window_offset, 32'h0);
    wr(ctrl_offset, 32'h0000_0102);
    wr(window_offset, 32'h0000_0000);
    rd_exp("ptr 10 window", window_offset, 32'h0);
    wr(ctrl_offset, 32'h0000_0101);
    rd_exp("weekday_digit kept", window_offset, 32'h0512);
    wr(ctrl_offset, 32'h0000_0100);
    rd_exp("min kept", window_offset, 32'h7f7f);
  endtask : t_ptr_unused

  initial
  begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_min_sec();
    t_weekday_digit_hr();
    t_wren_gate();
    t_unmapped();
    t_ptr_unused();
    tally_and_finish();
  end
endmodule : rtc_time_value_access_tb_top
